//--- bench/pcc_checker.sv
`timescale 1ns/100ps
module pcc_checker
  import pcc_pkg::*;
(
  input wire logic                      core_clk,
  input wire logic                      sys_rst,
  input wire logic [PCC_ADDR_WIDTH-1:0] reg_addr,
  input wire logic [PCC_DATA_WIDTH-1:0] reg_wr_data,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [PCC_DATA_WIDTH-1:0] reg_rd_data,
  input wire logic                      match_irq,
  input wire logic                      counter_out
);
  logic ie_q;
  logic te_q;
  logic off_q;
  wire  sc1_w = reg_wr && reg_addr == PCC_ADDR_STATUS_CONTROL;
  wire  sc2_w = reg_wr && reg_addr == PCC_ADDR_SOURCE_DIVIDER;
  wire  clr_w = sc1_w && (reg_wr_data[7] || !reg_wr_data[6]);
  // Enables shadowed from bus writes, so no internal state is needed
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ie_q <= 1'b0;
      te_q <= 1'b0;
      off_q <= 1'b1;
    end else begin
      if (sc1_w) begin
        ie_q <= reg_wr_data[6];
        te_q <= reg_wr_data[4];
      end
      if (sc2_w) off_q <= reg_wr_data[2:0] == 3'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_idle_a: assert property (!reg_rd |=> reg_rd_data == 8'h00)
    else $error("read data not zero outside read");
  rsv_status_a: assert property (reg_rd && reg_addr == PCC_ADDR_STATUS_CONTROL |=>
    reg_rd_data[5] == 1'b0 && reg_rd_data[3:0] == 4'h0) else $error("status reserved bits set");
  rsv_select_a: assert property (reg_rd && reg_addr == PCC_ADDR_SOURCE_DIVIDER |=>
    reg_rd_data[5:3] == 3'h0) else $error("select reserved bits set");
  w1c_clear_a: assert property (sc1_w && reg_wr_data[7] && off_q |=> !match_irq)
    else $error("request not cleared by flag write");
  irq_off_a: assert property (!ie_q && !$past(ie_q) |-> !match_irq)
    else $error("request while disabled");
  irq_hold_a: assert property (match_irq && !clr_w && !$past(clr_w) |=> match_irq)
    else $error("request dropped without clear");
  toggle_off_a: assert property (!te_q && !$past(te_q) |-> $stable(counter_out))
    else $error("output toggled while disabled");
  stop_hold_a: assert property (off_q && $past(off_q) |-> $stable(counter_out))
    else $error("output toggled while stopped");
  reset_out_a: assert property ($fell(sys_rst) |->
    counter_out && !match_irq && reg_rd_data == 8'h00) else $error("bad state after reset");
  cover property (match_irq);
  cover property ($fell(counter_out));
  cover property (sc1_w && reg_wr_data[7] && off_q);
endmodule : pcc_checker

bind pcc_top pcc_checker u_chk (.core_clk, .sys_rst, .reg_addr, .reg_wr_data, .reg_wr,
  .reg_rd, .reg_rd_data, .match_irq, .counter_out);

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import pcc_pkg::*;
  logic        core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic        osc_clk_in = 0, low_power_source = 0, match_irq, counter_out;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wr_data = 8'h00, reg_rd_data, exp_q[$], m;
  logic [7:0]  sc_t[4] = '{8'h81, 8'h82, 8'h01, 8'h41};
  int          miscompares = 0, n_checks = 0, cyc = 0, seed = 23743, r;
  pcc_top dut (.core_clk, .sys_rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .osc_clk_in,
    .low_power_source, .reg_rd_data, .match_irq, .counter_out);
  always #20 core_clk = ~core_clk;
  task close_out;
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Reads queue their expectation; the monitor below compares
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wr_data <= d;
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : acc
  task irq(input logic e);
    #1 check({7'h00, match_irq}, {7'h00, e});
  endtask : irq
  function automatic int ratio(input logic s, input int c);
    if (!s) return 1 << (c - 1);
    if (c == 6) return 100;
    if (c == 7) return 1000;
    return 128 << (c - 1);
  endfunction : ratio
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) if (rd_seen) check(reg_rd_data, exp_q.pop_front());
  // Slow sources as plain levels: oscillator period 8 cycles, low-power 16
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    osc_clk_in <= cyc[2];
    low_power_source <= cyc[3];
    if (cyc == 40000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) acc(0, PCC_ADDR_STATUS_CONTROL + 16'(i), 8'h00);
    acc(0, 16'h3070, 8'h00);
    acc(1, PCC_ADDR_STATUS_CONTROL, 8'hff);
    acc(0, PCC_ADDR_STATUS_CONTROL, 8'h50);
    acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'hff);
    acc(0, PCC_ADDR_SOURCE_DIVIDER, 8'hc7);
    for (int k = 0; k < 4; k++) begin
      m = (k == 0) ? 8'($random(seed) & 7) : 8'h00;
      acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'h00);
      acc(1, PCC_ADDR_STATUS_CONTROL, 8'hd0);
      acc(1, PCC_ADDR_MODULO_HIGH, 8'h00);
      acc(1, PCC_ADDR_MODULO_LOW, m);
      acc(0, PCC_ADDR_STATUS_CONTROL, 8'h50);
      irq(1'b0);
      acc(1, PCC_ADDR_SOURCE_DIVIDER, sc_t[k]);
      repeat (k == 3 ? 2300 : 24) @(posedge core_clk);
      acc(0, PCC_ADDR_STATUS_CONTROL, 8'hd0);
      irq(1'b1);
      acc(0, PCC_ADDR_MODULO_LOW, m);
    end
    acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'h00);
    acc(1, PCC_ADDR_STATUS_CONTROL, 8'h50);
    acc(0, PCC_ADDR_STATUS_CONTROL, 8'hd0);
    acc(1, PCC_ADDR_STATUS_CONTROL, 8'h80);
    acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'h81);
    repeat (10) @(posedge core_clk);
    acc(0, PCC_ADDR_STATUS_CONTROL, 8'h80);
    irq(1'b0);
    acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'h00);
    acc(1, PCC_ADDR_MODULO_HIGH, 8'hff);
    acc(1, PCC_ADDR_MODULO_LOW, 8'hff);
    // Code 1 on the bus clock with source 2'h2 is left to the match test: its count has no margin
    for (int s = 2; s < 4; s++) begin
      for (int c = (s == 2) ? 2 : 1; c < 8; c++) begin
        r = ratio(s[0], c);
        acc(1, PCC_ADDR_SOURCE_DIVIDER, {s[1:0], 3'h0, 3'(c)});
        repeat (3 * r + r / 2 - 2) @(posedge core_clk);
        acc(0, PCC_ADDR_COUNT_LOW, 8'h03);
        acc(0, PCC_ADDR_COUNT_HIGH, 8'h00);
      end
    end
    acc(0, PCC_ADDR_MODULO_HIGH, 8'hff);
    // Bus clock, ratio 1000, modulo 0: one overflow per 1000 cycles
    acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'h00);
    acc(1, PCC_ADDR_MODULO_HIGH, 8'h00);
    acc(1, PCC_ADDR_MODULO_LOW, 8'h00);
    acc(1, PCC_ADDR_STATUS_CONTROL, 8'h10);
    #1 m = {7'h00, counter_out};
    acc(1, PCC_ADDR_SOURCE_DIVIDER, 8'hc7);
    repeat (500) @(posedge core_clk);
    #1 check({7'h00, counter_out}, m);
    repeat (1000) @(posedge core_clk);
    #1 check({7'h00, counter_out}, {7'h00, ~m[0]});
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule : testbench

//--- include/pcc_pkg.sv
package pcc_pkg;

  localparam int unsigned PCC_ADDR_WIDTH = 16;
  localparam int unsigned PCC_DATA_WIDTH = 8;
  localparam int unsigned PCC_COUNT_WIDTH = 16;
  localparam int unsigned PCC_PRESC_WIDTH = 11;

  // Register addresses
  localparam logic [15:0] PCC_ADDR_STATUS_CONTROL = 16'h306a;
  localparam logic [15:0] PCC_ADDR_SOURCE_DIVIDER = 16'h306b;
  localparam logic [15:0] PCC_ADDR_MODULO_HIGH = 16'h306c;
  localparam logic [15:0] PCC_ADDR_MODULO_LOW = 16'h306d;
  localparam logic [15:0] PCC_ADDR_COUNT_HIGH = 16'h306e;
  localparam logic [15:0] PCC_ADDR_COUNT_LOW = 16'h306f;

  // Field positions of counter_status_control
  localparam int unsigned PCC_BIT_MATCH_FLAG = 7;
  localparam int unsigned PCC_BIT_MATCH_IRQ_ENABLE = 6;
  localparam int unsigned PCC_BIT_TOGGLE_OUTPUT_ENABLE = 4;

  // Field positions of source_divider_select
  localparam int unsigned PCC_SOURCE_MSB = 7;
  localparam int unsigned PCC_SOURCE_LSB = 6;
  localparam int unsigned PCC_DIVIDER_MSB = 2;
  localparam int unsigned PCC_DIVIDER_LSB = 0;

  // Reset values
  localparam logic [1:0] PCC_SOURCE_RESET = 2'h0;
  localparam logic [2:0] PCC_DIVIDER_RESET = 3'h0;
  localparam logic [15:0] PCC_MODULO_RESET = 16'h0000;
  localparam logic [15:0] PCC_COUNT_RESET = 16'h0000;
  localparam logic PCC_COUNTER_OUT_RESET = 1'b1;

  // Source select codes; 2'h2 and 2'h3 both pick the bus clock
  localparam logic [1:0] PCC_SOURCE_OSC = 2'h0;
  localparam logic [1:0] PCC_SOURCE_LOW_POWER = 2'h1;
  localparam logic [2:0] PCC_DIVIDER_OFF = 3'h0;

  // Decimal ratios of the low-power / odd source branch
  localparam logic [11:0] PCC_RATIO_DEC_100 = 12'h064;
  localparam logic [11:0] PCC_RATIO_DEC_1000 = 12'h3e8;
  localparam logic [2:0] PCC_DIVIDER_DEC_100 = 3'h6;
  localparam logic [2:0] PCC_DIVIDER_DEC_1000 = 3'h7;
  localparam int unsigned PCC_BINARY_SHIFT_ODD = 6;

  localparam int unsigned PCC_SYNC_STAGES = 2;

endpackage : pcc_pkg

//--- verilog/pcc_sync.sv
`timescale 1ns/100ps
module pcc_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : pcc_sync

//--- verilog/pcc_top.sv
// Summary of operation
// - Match flag, bit 7 of status control, sets when counter hits modulo.
// - Writing one clears flag and interrupt request; writing zero does nothing.
// - Reset clears the match flag.
// - With interrupt enable bit 6 set, a set flag raises the request.
// - Interrupt enable resets to zero; then no request, software polls.
// - Reserved bits read zero and ignore writes.
// - Toggle-output enable bit 4 set: output pin inverts on each overflow.
// - Toggle-output enable clear: output pin holds its level.
// - Source select bits 7-6: 00 oscillator, 01 low-power, 1x bus clock.
// - Changing source select clears prescaler and main counter.
// - Reset sets source select to 00.
// - Divider code 000 turns the prescaler off; counter stops.
// - Source low bit zero: codes 1..7 divide by 1 to 64.
// - Source low bit one: 128..2048, then 100 and 1000.
// - Changing divider select clears prescaler and main counter.
// - Reset clears divider select, prescaler off.
// - 16-bit modulo from two bytes; match resets count and sets flag.
// - Modulo zero sets the flag on every prescaler output tick.
// - Reset clears the modulo value.
// - Reading count low byte latches high byte for a coherent read.
// - New modulo takes effect at overflow or on nonzero divider write.
// - Flag sets on the step from modulo value back to zero.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module pcc_top
  import pcc_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = PCC_COUNT_WIDTH,
  parameter int unsigned PRESC_WIDTH = PCC_PRESC_WIDTH
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic [PCC_ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [PCC_DATA_WIDTH-1:0] reg_wr_data,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic                      osc_clk_in,
  input  wire logic                      low_power_source,
  output logic      [PCC_DATA_WIDTH-1:0] reg_rd_data,
  output logic                           match_irq,
  output logic                           counter_out
);

  typedef struct packed {
    logic                      match_flag;
    logic                      match_irq_enable;
    logic                      toggle_output_enable;
    logic [1:0]                source_select;
    logic [2:0]                divider_select;
    logic [COUNT_WIDTH-1:0]    modulo_buffer;
    logic [COUNT_WIDTH-1:0]    modulo_active;
    logic [COUNT_WIDTH-1:0]    main_counter;
    logic [PRESC_WIDTH-1:0]    prescaler;
    logic [7:0]                count_high_latch;
    logic                      osc_last;
    logic                      low_power_last;
    logic [PCC_DATA_WIDTH-1:0] rd_data;
    logic                      irq;
    logic                      out_level;
  } pcc_state_type;

  pcc_state_type state;
  pcc_state_type next_state;

  logic [1:0] sync_level;

  // Divide ratio for a given source and divider code; zero means off
  function automatic logic [11:0] pcc_ratio(input logic [1:0] src, input logic [2:0] div);
    logic [11:0] ratio;
    ratio = 12'h000;
    if (div == PCC_DIVIDER_OFF) begin
      ratio = 12'h000;
    end else if (!src[0]) begin
      ratio = 12'h001 << (div - 3'h1);
    end else if (div == PCC_DIVIDER_DEC_100) begin
      ratio = PCC_RATIO_DEC_100;
    end else if (div == PCC_DIVIDER_DEC_1000) begin
      ratio = PCC_RATIO_DEC_1000;
    end else begin
      ratio = 12'h001 << (PCC_BINARY_SHIFT_ODD + 32'(div));
    end
    return ratio;
  endfunction : pcc_ratio

  // Register read mux; reserved bits stay zero
  function automatic logic [7:0] pcc_read(input pcc_state_type s, input logic [15:0] addr);
    logic [7:0] value;
    value = 8'h00;
    unique case (addr)
      PCC_ADDR_STATUS_CONTROL: begin
        value[PCC_BIT_MATCH_FLAG]           = s.match_flag;
        value[PCC_BIT_MATCH_IRQ_ENABLE]     = s.match_irq_enable;
        value[PCC_BIT_TOGGLE_OUTPUT_ENABLE] = s.toggle_output_enable;
      end
      PCC_ADDR_SOURCE_DIVIDER: begin
        value[PCC_SOURCE_MSB:PCC_SOURCE_LSB]   = s.source_select;
        value[PCC_DIVIDER_MSB:PCC_DIVIDER_LSB] = s.divider_select;
      end
      PCC_ADDR_MODULO_HIGH: begin
        value = s.modulo_buffer[15:8];
      end
      PCC_ADDR_MODULO_LOW: begin
        value = s.modulo_buffer[7:0];
      end
      PCC_ADDR_COUNT_HIGH: begin
        value = s.count_high_latch;
      end
      PCC_ADDR_COUNT_LOW: begin
        value = s.main_counter[7:0];
      end
      default: begin
        value = 8'h00;
      end
    endcase
    return value;
  endfunction : pcc_read

  // Slow sources cross into the core clock before any edge is taken
  pcc_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({low_power_source, osc_clk_in}),
    .sync_out (sync_level)
  );

  logic        osc_rise;
  logic        low_power_rise;
  logic        source_tick;
  logic [11:0] ratio;
  logic        presc_tick;
  logic        wr_status;
  logic        wr_select;
  logic        select_changed;
  logic        new_source_diff;
  logic        new_divider_diff;
  logic [1:0]  new_source;
  logic [2:0]  new_divider;
  logic        at_match;
  logic        overflow;

  always_comb begin
    osc_rise = sync_level[0] && !state.osc_last;
    low_power_rise = sync_level[1] && !state.low_power_last;

    unique case (state.source_select)
      PCC_SOURCE_OSC: begin
        source_tick = osc_rise;
      end
      PCC_SOURCE_LOW_POWER: begin
        source_tick = low_power_rise;
      end
      default: begin
        source_tick = 1'b1;
      end
    endcase

    ratio      = pcc_ratio(state.source_select, state.divider_select);
    presc_tick = (ratio != 12'h000) && source_tick &&
                 (32'(state.prescaler) == 32'(ratio) - 32'd1);

    wr_status        = reg_wr && (reg_addr == PCC_ADDR_STATUS_CONTROL);
    wr_select        = reg_wr && (reg_addr == PCC_ADDR_SOURCE_DIVIDER);
    new_source       = reg_wr_data[PCC_SOURCE_MSB:PCC_SOURCE_LSB];
    new_divider      = reg_wr_data[PCC_DIVIDER_MSB:PCC_DIVIDER_LSB];
    new_source_diff  = wr_select && (new_source != state.source_select);
    new_divider_diff = wr_select && (new_divider != state.divider_select);
    select_changed   = new_source_diff || new_divider_diff;

    at_match = (state.main_counter == state.modulo_active);
    overflow = presc_tick && at_match && !select_changed;
  end

  always_comb begin
    next_state = state;
    next_state.osc_last = sync_level[0];
    next_state.low_power_last = sync_level[1];

    // Prescaler runs only while a ratio is selected
    if (presc_tick) begin
      next_state.prescaler = '0;
    end else if (source_tick && ratio != 12'h000) begin
      next_state.prescaler = state.prescaler + PRESC_WIDTH'(1);
    end

    // Main counter steps on each prescaler output tick
    if (presc_tick) begin
      if (at_match) begin
        next_state.main_counter  = PCC_COUNT_RESET;
        next_state.modulo_active = state.modulo_buffer;
      end else begin
        next_state.main_counter = state.main_counter + COUNT_WIDTH'(1);
      end
    end

    // Status control write
    if (wr_status) begin
      next_state.match_irq_enable     = reg_wr_data[PCC_BIT_MATCH_IRQ_ENABLE];
      next_state.toggle_output_enable = reg_wr_data[PCC_BIT_TOGGLE_OUTPUT_ENABLE];
      if (reg_wr_data[PCC_BIT_MATCH_FLAG]) begin
        next_state.match_flag = 1'b0;
      end
    end

    // A match in the same cycle as a clear keeps the flag set
    if (overflow) begin
      next_state.match_flag = 1'b1;
    end

    // Output pin toggles only when enabled
    if (overflow && state.toggle_output_enable) begin
      next_state.out_level = !state.out_level;
    end else begin
      next_state.out_level = state.out_level;
    end

    // Source and divider write
    if (wr_select) begin
      next_state.source_select  = new_source;
      next_state.divider_select = new_divider;
      if (new_divider != PCC_DIVIDER_OFF) begin
        next_state.modulo_active = state.modulo_buffer;
      end
    end
    if (select_changed) begin
      next_state.prescaler    = '0;
      next_state.main_counter = PCC_COUNT_RESET;
    end

    // Modulo bytes go to the buffer only
    if (reg_wr && reg_addr == PCC_ADDR_MODULO_HIGH) begin
      next_state.modulo_buffer[15:8] = reg_wr_data;
    end
    if (reg_wr && reg_addr == PCC_ADDR_MODULO_LOW) begin
      next_state.modulo_buffer[7:0] = reg_wr_data;
    end

    // Reading the low byte freezes the high byte for the next read
    if (reg_rd && reg_addr == PCC_ADDR_COUNT_LOW) begin
      next_state.count_high_latch = state.main_counter[15:8];
    end

    next_state.rd_data = reg_rd ? pcc_read(state, reg_addr) : 8'h00;

    // Request follows the flag gated by the enable
    next_state.irq = next_state.match_flag && next_state.match_irq_enable;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state.match_flag           <= 1'b0;
      state.match_irq_enable     <= 1'b0;
      state.toggle_output_enable <= 1'b0;
      state.source_select        <= PCC_SOURCE_RESET;
      state.divider_select       <= PCC_DIVIDER_RESET;
      state.modulo_buffer        <= PCC_MODULO_RESET;
      state.modulo_active        <= PCC_MODULO_RESET;
      state.main_counter         <= PCC_COUNT_RESET;
      state.prescaler            <= '0;
      state.count_high_latch     <= 8'h00;
      state.osc_last             <= 1'b0;
      state.low_power_last       <= 1'b0;
      state.rd_data              <= 8'h00;
      state.irq                  <= 1'b0;
      state.out_level            <= PCC_COUNTER_OUT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rd_data = state.rd_data;
  assign match_irq   = state.irq;
  assign counter_out = state.out_level;

endmodule : pcc_top
